//--- core/fdhr_map.vh
// Constants shared by the host register protocol block
// How it works
// R1 - Host supplies sector addresses from one to twenty-six decimal.
// R2 - Sector address requested only by write, read and write-deleted functions.
// R3 - Twelve-bit word length: all twelve buffer bits carry data.
// R4 - Eight-bit word length: only bits four to eleven carry data.
// R5 - After any function but read error, status waits in interface register.
// R6 - Status bit 4 drive ready; mode 1 valid after read status or init.
// R7 - Mode 2 drive ready valid only after read status.
// R8 - Status bit 5 set on deleted mark read or write-deleted function.
// R9 - Mode 1 bits 0-3 and 6-8 unused; mode 2 bits 0-3 unused.
// R10 - Mode 2 status bit 6 shows diskette density, one for double.
// R11 - Mode 2 density mismatch sets bit 7, ends function, error and done.
// R12 - Mode 2 status bit 8 reads set.
// R13 - Status bit 9 set when power-up or programmed init tasks finish.
// R14 - Status bit 10 set on wrong parity of a shifted command.
// R15 - Status bit 11 set on CRC failure while reading a sector.
// R16 - Host starts each function with the load command instruction.
// R17 - Host tests and clears done before issuing a command.
// R18 - Fill buffer raises transfer request once per word still needed.
// R19 - Host clears transfer request by skip, then passes one word.
// R20 - All fill words in: done set, interrupt if enabled.
// R21 - Transfer instruction after done delivers the status word.
// R22 - Fill count 128/64 mode 1; mode 2 256/128 or 128/64 by density.
// R23 - Transfer request skip skips when set and clears the flag.
// R24 - Error is always set together with done.
// R25 - Command bit 5 clear for twelve-bit, set for eight-bit words.
// R26 - Unused status positions read as zero.
`ifndef FDHR_MAP_VH
`define FDHR_MAP_VH

// Bit n of the host word sits at vector index 11-n
`define FD_CMD_FN_HI   3
`define FD_CMD_FN_LO   1
`define FD_CMD_DRV     4
`define FD_CMD_WL8     6
`define FD_CMD_DEN     7
`define FD_AC_IE       0

`define FD_FN_FILL     3'h0
`define FD_FN_EMPTY    3'h1
`define FD_FN_WRSEC    3'h2
`define FD_FN_RDSEC    3'h3
`define FD_FN_DENS     3'h4
`define FD_FN_RDSTAT   3'h5
`define FD_FN_WRDEL    3'h6
`define FD_FN_RDERR    3'h7

`define FD_ST_CRC      0
`define FD_ST_PAR      1
`define FD_ST_INIT     2
`define FD_ST_MODE2    3
`define FD_ST_DENERR   4
`define FD_ST_DDEN     5
`define FD_ST_DEL      6
`define FD_ST_DRDY     7
`define FD_ST_RESET    12'h000
`define FD_ST_KEEP     12'h084
`define FD_ST_MASK1    12'h0c7
`define FD_ST_MASK2    12'h0ff
`define FD_WL8_MASK    12'h0ff

`define FD_CNT_64      9'h040
`define FD_CNT_128     9'h080
`define FD_CNT_256     9'h100

`endif

//--- core/fdhr_buf2.v
// Two-entry valid/ready buffer for sector buffer words
`timescale 1ns/1ps
module fdhr_buf2 (
  input  wire        clk,
  input  wire        arst_n,
  input  wire [11:0] in_data,
  input  wire        in_valid,
  output wire        in_ready,
  output wire [11:0] out_data,
  output wire        out_valid,
  input  wire        out_ready
);
  reg [11:0] mem [0:1];
  reg        wr_ptr;
  reg        rd_ptr;
  reg [1:0]  fill;
  wire       push;
  wire       pop;

  assign in_ready  = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem[0] <= 12'h000;
      mem[1] <= 12'h000;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push & ~pop)
        fill <= fill + 2'h1;
      else if (pop & ~push)
        fill <= fill - 2'h1;
    end
  end
endmodule // fdhr_buf2

//--- core/fdhr_ctrl.v
// Host-facing interface register and function sequencer
`timescale 1ns/1ps
`include "fdhr_map.vh"
module fdhr_ctrl (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        mode2_strap,
  input  wire        lcd_stb,
  input  wire        xdr_stb,
  input  wire        str_stb,
  input  wire        ser_stb,
  input  wire        sdn_stb,
  input  wire        intr_stb,
  input  wire        init_stb,
  input  wire [11:0] ac_in,
  output reg  [11:0] ac_out,
  output reg         ac_load,
  output wire        skip,
  output wire        irq,
  output reg         xfer_req,
  output reg         done_flag,
  output reg         err_flag,
  output reg         init_req,
  input  wire        init_cplt,
  input  wire        drive_ready,
  input  wire        disk_dd,
  input  wire        parity_err,
  input  wire [7:0]  err_code,
  output reg         op_start,
  output reg  [2:0]  op_func,
  output reg         op_dd,
  output reg         drive_sel,
  output reg  [11:0] sect_addr,
  output reg         sect_stb,
  input  wire        op_cplt,
  input  wire        op_crc_err,
  input  wire        op_deleted,
  input  wire        op_fail,
  output wire [11:0] sb_data,
  output wire        sb_valid,
  input  wire        sb_ready
);
  localparam [5:0] S_INIT = 6'h01;
  localparam [5:0] S_IDLE = 6'h02;
  localparam [5:0] S_DEC  = 6'h04;
  localparam [5:0] S_FILL = 6'h08;
  localparam [5:0] S_SADR = 6'h10;
  localparam [5:0] S_OPER = 6'h20;

  reg  [5:0]  state;
  reg  [11:0] cmd;
  reg  [11:0] st;
  reg  [11:0] iface;
  reg  [11:0] stw;
  reg  [8:0]  cnt;
  reg  [8:0]  tgt;
  reg         mode2;
  reg         strap_s1;
  reg         strap_s2;
  reg         ie;
  reg         pub;
  reg         pub_err;
  reg         push_v;
  reg  [11:0] push_d;
  wire        push_rdy;
  wire [2:0]  fn;
  wire        wl8;
  wire        cmd_dd;
  wire        den_bad;
  wire [11:0] word_in;

  assign fn     = cmd[`FD_CMD_FN_HI:`FD_CMD_FN_LO];
  assign wl8    = cmd[`FD_CMD_WL8]; // R25
  assign cmd_dd = cmd[`FD_CMD_DEN];

  // Mode 1 always expects single density media
  assign den_bad = mode2 ? (disk_dd != cmd_dd) : disk_dd;

  // Eight-bit words keep only the low eight bits
  assign word_in = wl8 ? (ac_in & `FD_WL8_MASK) : ac_in; // R4 R3

  assign skip = (str_stb & xfer_req)
              | (sdn_stb & done_flag)
              | (ser_stb & err_flag); // R23

  assign irq = ie & done_flag; // R20

  // Words needed to fill the sector buffer
  always @* begin
    if (!mode2)
      tgt = wl8 ? `FD_CNT_128 : `FD_CNT_64; // R22
    else if (cmd_dd)
      tgt = wl8 ? `FD_CNT_256 : `FD_CNT_128; // R22
    else
      tgt = wl8 ? `FD_CNT_128 : `FD_CNT_64; // R22
  end

  // Status word as the host sees it
  always @* begin
    stw = st;
    stw[`FD_ST_MODE2] = mode2; // R12
    stw[`FD_ST_DDEN]  = mode2 & disk_dd; // R10
    if (mode2)
      stw = stw & `FD_ST_MASK2; // R9 R26
    else
      stw = stw & `FD_ST_MASK1; // R9 R26
  end

  // Mode strap comes from a pin
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      strap_s1 <= mode2_strap;
      strap_s2 <= strap_s1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= S_INIT;
      cmd       <= 12'h000;
      st        <= `FD_ST_RESET;
      iface     <= 12'h000;
      cnt       <= 9'h000;
      mode2     <= 1'b0;
      ie        <= 1'b0;
      pub       <= 1'b0;
      pub_err   <= 1'b0;
      push_v    <= 1'b0;
      push_d    <= 12'h000;
      ac_out    <= 12'h000;
      ac_load   <= 1'b0;
      xfer_req  <= 1'b0;
      done_flag <= 1'b0;
      err_flag  <= 1'b0;
      init_req  <= 1'b1;
      op_start  <= 1'b0;
      op_func   <= 3'h0;
      op_dd     <= 1'b0;
      drive_sel <= 1'b0;
      sect_addr <= 12'h000;
      sect_stb  <= 1'b0;
    end else begin
      op_start <= 1'b0;
      sect_stb <= 1'b0;
      ac_load  <= 1'b0;
      pub      <= 1'b0;
      pub_err  <= 1'b0;

      // Host clears come first so a same-cycle set wins
      if (str_stb)
        xfer_req <= 1'b0; // R23
      if (sdn_stb)
        done_flag <= 1'b0;
      if (ser_stb)
        err_flag <= 1'b0;
      if (intr_stb)
        ie <= ac_in[`FD_AC_IE];
      if (parity_err)
        st[`FD_ST_PAR] <= 1'b1; // R14

      if (xdr_stb && done_flag) begin
        ac_out  <= iface; // R21
        ac_load <= 1'b1;
      end

      // Publish the finished function's status
      if (pub) begin
        iface     <= stw; // R5
        done_flag <= 1'b1; // R20
        if (pub_err)
          err_flag <= 1'b1; // R24
      end

      case (state)
        S_INIT: begin
          if (init_cplt) begin
            mode2    <= strap_s2;
            init_req <= 1'b0;
            st       <= `FD_ST_RESET;
            st[`FD_ST_INIT] <= 1'b1; // R13
            // Drive ready is trusted after init only in mode 1
            st[`FD_ST_DRDY] <= ~strap_s2 & drive_ready; // R6 R7
            pub      <= 1'b1;
            state    <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (lcd_stb && !done_flag && !pub) begin
            cmd       <= ac_in; // R16
            drive_sel <= ac_in[`FD_CMD_DRV];
            st        <= st & `FD_ST_KEEP;
            state     <= S_DEC;
          end
        end
        S_DEC: begin
          case (fn)
            `FD_FN_FILL: begin
              cnt      <= tgt; // R22
              xfer_req <= 1'b1; // R18
              state    <= S_FILL;
            end
            `FD_FN_WRSEC, `FD_FN_RDSEC, `FD_FN_WRDEL: begin
              st       <= `FD_ST_RESET;
              xfer_req <= 1'b1; // R2
              state    <= S_SADR;
            end
            `FD_FN_RDSTAT: begin
              st[`FD_ST_DRDY] <= drive_ready; // R6 R7
              pub   <= 1'b1;
              state <= S_IDLE;
            end
            `FD_FN_DENS: begin
              if (!mode2)
                st[`FD_ST_INIT] <= 1'b0;
              pub   <= 1'b1;
              state <= S_IDLE;
            end
            `FD_FN_RDERR: begin
              // Error code replaces the status word here
              iface     <= {4'h0, err_code}; // R5
              done_flag <= 1'b1;
              state     <= S_IDLE;
            end
            default: begin
              pub   <= 1'b1;
              state <= S_IDLE;
            end
          endcase
        end
        S_FILL: begin
          if (push_v) begin
            if (push_rdy) begin
              push_v <= 1'b0;
              if (cnt == 9'h000) begin
                pub   <= 1'b1; // R20
                state <= S_IDLE;
              end else begin
                xfer_req <= 1'b1; // R18
              end
            end
          end else if (xdr_stb && !done_flag) begin
            push_v <= 1'b1;
            push_d <= word_in; // R3 R4
            cnt    <= cnt - 9'h001;
          end
        end
        S_SADR: begin
          if (xdr_stb && !done_flag) begin
            sect_addr <= ac_in; // R2
            sect_stb  <= 1'b1;
            op_func   <= fn; // R2
            if (den_bad) begin
              if (mode2)
                st[`FD_ST_DENERR] <= 1'b1; // R11
              pub     <= 1'b1; // R11
              pub_err <= 1'b1; // R11
              state   <= S_IDLE;
            end else begin
              op_start <= 1'b1;
              op_dd    <= mode2 & cmd_dd;
              state    <= S_OPER;
            end
          end
        end
        S_OPER: begin
          if (op_cplt) begin
            if (op_crc_err && fn == `FD_FN_RDSEC)
              st[`FD_ST_CRC] <= 1'b1; // R15
            if ((fn == `FD_FN_RDSEC && op_deleted) ||
                (fn == `FD_FN_WRDEL && !op_fail))
              st[`FD_ST_DEL] <= 1'b1; // R8
            pub     <= 1'b1;
            pub_err <= op_fail | (op_crc_err & (fn == `FD_FN_RDSEC));
            state   <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase

      // Programmed init restarts the sequencer and clears the flags, interrupt enable and status
      if (init_stb) begin
        state     <= S_INIT;
        init_req  <= 1'b1;
        ie        <= 1'b0;
        xfer_req  <= 1'b0;
        done_flag <= 1'b0;
        err_flag  <= 1'b0;
        push_v    <= 1'b0;
        pub       <= 1'b0;
        st        <= `FD_ST_RESET;
      end
    end
  end

  // Stalls toward the sector buffer hold back the next request
  fdhr_buf2 u_buf (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_data   (push_d),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .out_data  (sb_data),
    .out_valid (sb_valid),
    .out_ready (sb_ready)
  );
endmodule // fdhr_ctrl

//--- tb/fdhr_ctrl_checker.sv
// Assertion checker for the host register protocol block
`timescale 1ns/1ps
module fdhr_checker (
  input logic        clk,
  input logic        arst_n,
  input logic        xdr_stb,
  input logic        str_stb,
  input logic        init_stb,
  input logic        op_cplt,
  input logic        skip,
  input logic        irq,
  input logic        xfer_req,
  input logic        done_flag,
  input logic        err_flag,
  input logic        ac_load,
  input logic        sect_stb,
  input logic [2:0]  op_func,
  input logic [11:0] sb_data,
  input logic        sb_valid,
  input logic        sb_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_str; str_stb && xfer_req |-> skip ##1 !xfer_req; endproperty
  a_str: assert property (p_str) else $error("str skip");
  property p_hold; xfer_req && !str_stb && !init_stb |=> xfer_req; endproperty
  a_hold: assert property (p_hold) else $error("xreq lost");
  property p_err; $rose(err_flag) |-> done_flag; endproperty
  a_err: assert property (p_err) else $error("err no done");
  property p_irq; irq |-> done_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq no done");
  property p_xdr; xdr_stb && done_flag |=> ac_load; endproperty
  a_xdr: assert property (p_xdr) else $error("no status load");
  property p_sect; sect_stb |-> op_func inside {3'h2, 3'h3, 3'h6}; endproperty
  a_sect: assert property (p_sect) else $error("sector func");
  property p_cplt; op_cplt |-> ##2 done_flag; endproperty
  a_cplt: assert property (p_cplt) else $error("late done");
  property p_sb; sb_valid && !sb_ready |=> sb_valid && $stable(sb_data);
  endproperty
  a_sb: assert property (p_sb) else $error("buffer word lost");
  c_irq: cover property ($rose(done_flag) && irq);
  c_err: cover property ($rose(err_flag));
  c_sect: cover property (sect_stb);
endmodule // fdhr_checker

bind fdhr_ctrl fdhr_checker i_chk (
  .clk(clk), .arst_n(arst_n), .xdr_stb(xdr_stb), .str_stb(str_stb),
  .init_stb(init_stb), .op_cplt(op_cplt), .skip(skip), .irq(irq),
  .xfer_req(xfer_req), .done_flag(done_flag), .err_flag(err_flag),
  .ac_load(ac_load), .sect_stb(sect_stb), .op_func(op_func),
  .sb_data(sb_data), .sb_valid(sb_valid), .sb_ready(sb_ready));

//--- tb/fdhr_drv_model.sv
// Drive-side model: init, sector operations, buffer drain
`timescale 1ns/1ps
module fdhr_drv_model (
  input  logic       clk,
  input  logic       arst_n,
  input  logic       init_req,
  input  logic       op_start,
  input  logic [2:0] op_func,
  output logic       init_cplt,
  output logic       op_cplt,
  output logic       sb_ready
);
  logic [3:0] icnt, ocnt, scnt;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {icnt, ocnt, scnt} <= 12'h000;
      {init_cplt, op_cplt, sb_ready} <= 3'h0;
    end else begin
      icnt <= init_req ? icnt + 4'h1 : 4'h0;
      init_cplt <= init_req && icnt == 4'h6;
      scnt <= scnt + 4'h1;
      // Long stalls so the buffer fills
      sb_ready <= &scnt[3:2];
      op_cplt <= ocnt == 4'h1;
      if (op_start && op_func inside {3'h2, 3'h3, 3'h6}) begin
        ocnt <= 4'h9;
      end else if (ocnt != 4'h0) begin
        ocnt <= ocnt - 4'h1;
      end
    end
  end
endmodule // fdhr_drv_model

//--- tb/testbench.sv
// Self-checking bench for the host register protocol block
`timescale 1ns/1ps
module testbench;
  logic        clk, arst_n, mode2_strap, drive_ready, disk_dd, s, ld;
  logic        parity_err, op_crc_err, op_deleted, op_fail, op_dd;
  logic [6:0]  stb;
  logic [11:0] ac_in, ac_out, sect_addr, sb_data, w;
  logic [7:0]  err_code;
  logic [2:0]  op_func;
  logic        ac_load, skip, irq, xfer_req, done_flag, err_flag;
  logic        init_req, init_cplt, op_start, drive_sel, sect_stb;
  logic        op_cplt, sb_valid, sb_ready;
  logic [11:0] sbq[$];
  int          num_errors, cmp_count;
  fdhr_ctrl i_dut (.clk(clk), .arst_n(arst_n), .mode2_strap(mode2_strap),
    .lcd_stb(stb[0]), .xdr_stb(stb[1]), .str_stb(stb[2]), .ser_stb(stb[3]),
    .sdn_stb(stb[4]), .intr_stb(stb[5]), .init_stb(stb[6]), .ac_in(ac_in),
    .ac_out(ac_out), .ac_load(ac_load), .skip(skip), .irq(irq),
    .xfer_req(xfer_req), .done_flag(done_flag), .err_flag(err_flag),
    .init_req(init_req), .init_cplt(init_cplt), .drive_ready(drive_ready),
    .disk_dd(disk_dd), .parity_err(parity_err), .err_code(err_code),
    .op_start(op_start), .op_func(op_func), .op_dd(op_dd),
    .drive_sel(drive_sel), .sect_addr(sect_addr), .sect_stb(sect_stb),
    .op_cplt(op_cplt), .op_crc_err(op_crc_err), .op_deleted(op_deleted),
    .op_fail(op_fail), .sb_data(sb_data), .sb_valid(sb_valid),
    .sb_ready(sb_ready));
  fdhr_drv_model i_drv (.clk(clk), .arst_n(arst_n), .init_req(init_req),
    .op_start(op_start), .op_func(op_func), .init_cplt(init_cplt),
    .op_cplt(op_cplt), .sb_ready(sb_ready));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (sb_valid && sb_ready) sbq.push_back(sb_data);
  task automatic chk(input string n, input logic [11:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // One host instruction, then an idle cycle
  task automatic ins(input int k, input logic [11:0] a);
    stb[k] = 1'b1;
    ac_in = a;
    #6 s = skip;
    @(posedge clk);
    #1 stb[k] = 1'b0;
    ld = ac_load;
    @(posedge clk);
    #1;
  endtask
  task automatic wt(input bit d);
    for (int t = 0; t < 300 && (d ? done_flag : xfer_req) !== 1'b1;
         t++) begin
      @(posedge clk);
      #1;
    end
    chk("flag", 12'h001, {11'h0, d ? done_flag : xfer_req});
  endtask
  task automatic stat;
    wt(1);
    ins(1, 12'h000);
    chk("load", 12'h001, {11'h0, ld});
    w = ac_out;
    ins(4, 12'h000);
    chk("sdn", 12'h001, {11'h0, s});
  endtask
  task automatic fill(input logic b8, input int n, input logic ie);
    ins(5, {11'h0, ie});
    sbq.delete();
    ins(0, {5'h0, b8, 6'h00});
    for (int i = 0; i < n; i++) begin
      wt(0);
      ins(2, 12'h000);
      chk("str", 12'h001, {11'h0, s});
      ins(1, 12'ha5c ^ 12'(i));
    end
    wt(1);
    chk("irq", {11'h0, ie}, {11'h0, irq});
    for (int i = 0; i < 100 && sbq.size() < n; i++) begin
      @(posedge clk);
      #1;
    end
    chk("count", 12'(n), 12'(sbq.size()));
    for (int i = 0; i < n; i++)
      chk("word", b8 ? {4'h0, 8'h5c ^ 8'(i)} : 12'ha5c ^ 12'(i), sbq[i]);
    stat();
    chk("unused", 12'h000, w & (mode2_strap ? 12'hf00 : 12'hf38));
    $display("fill of %0d words finished", n);
  endtask
  task automatic sect(input logic [2:0] f, input logic den,
                      input logic [11:0] m, x, input logic e);
    ins(0, {4'h0, den, 3'h0, f, 1'b0});
    wt(0);
    ins(2, 12'h000);
    ins(1, 12'h01a);
    chk("sector", 12'h01a, sect_addr);
    parity_err = 1'b1;
    @(posedge clk);
    #1 parity_err = 1'b0;
    stat();
    chk("status", x, w & m);
    ins(3, 12'h000);
    chk("ser", {11'h0, e}, {11'h0, s});
    $display("sector function %0d finished", f);
  endtask
  task automatic simp(input logic [2:0] f, input logic [11:0] m, x);
    ins(0, {8'h00, f, 1'b0});
    stat();
    chk("simple", x, w & m);
    $display("function %0d finished", f);
  endtask
  task automatic complete_run;
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
  initial begin
    stb = 7'h00;
    ac_in = 12'h000;
    mode2_strap = 1'b0;
    drive_ready = 1'b1;
    disk_dd = 1'b0;
    parity_err = 1'b0;
    op_crc_err = 1'b0;
    op_deleted = 1'b0;
    op_fail = 1'b0;
    err_code = 8'h5a;
    num_errors = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    stat();
    chk("init", 12'h084, w);
    fill(1'b0, 64, 1'b1);
    fill(1'b1, 128, 1'b0);
    op_crc_err = 1'b1;
    sect(3'h3, 1'b0, 12'hfff, 12'h003, 1'b1);
    op_crc_err = 1'b0;
    op_deleted = 1'b1;
    sect(3'h3, 1'b0, 12'hfff, 12'h042, 1'b0);
    op_deleted = 1'b0;
    sect(3'h6, 1'b0, 12'hfff, 12'h042, 1'b0);
    simp(3'h5, 12'hfff, 12'h080);
    simp(3'h7, 12'hfff, 12'h05a);
    simp(3'h4, 12'h004, 12'h000);
    mode2_strap = 1'b1;
    disk_dd = 1'b1;
    ins(6, 12'h000);
    stat();
    chk("init2", 12'h02c, w);
    fill(1'b0, 64, 1'b0);
    sect(3'h2, 1'b0, 12'hfff, 12'h038, 1'b1);
    sect(3'h2, 1'b1, 12'hfff, 12'h02a, 1'b0);
    simp(3'h5, 12'hfff, 12'h0a8);
    complete_run();
  end
endmodule // testbench
